// ==== design/dtw_pkg.sv ====
// Constants shared by the remap table walker: register map, entry
// field positions, fault cause codes and reset values.
// Assumes a 32-bit register port and 128-bit table reads.
`default_nettype none

package dtw_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ROOT_LO = 8'h04;
  localparam logic [7:0] REG_ROOT_HI = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic       CTRL_RST    = 1'b0;
  localparam logic [63:0] ROOT_RST   = 64'h0;
  // ==========================================================
  // Entry field positions
  localparam int PRESENT_BIT = 0;
  localparam int SILENCE_BIT = 1;
  localparam int PTE_RD_BIT  = 0;
  localparam int PTE_WR_BIT  = 1;
  localparam int STOP_BIT    = 7;
  localparam int TAG_LSB     = 72;
  localparam int GW_LSB      = 64;
  localparam int REC_TYPE    = 126;
  localparam int REC_CAUSE   = 96;
  localparam int REC_REQ     = 64;
  localparam int PAGE_LSB    = 12;
  localparam int LVL_BITS    = 9;
  localparam logic [2:0] GW_MAX    = 3'd4;
  localparam logic [6:0] GW_BASE   = 7'd30;
  localparam logic [7:0] STOP_DEF  = 8'h3c;
  // ==========================================================
  // Fault cause codes
  localparam logic [7:0] FC_NONE     = 8'h00;
  localparam logic [7:0] FC_ROOT_NP  = 8'h01;
  localparam logic [7:0] FC_ROOT_RSV = 8'h02;
  localparam logic [7:0] FC_CTX_NP   = 8'h03;
  localparam logic [7:0] FC_CTX_RSV  = 8'h04;
  localparam logic [7:0] FC_WIDTH    = 8'h05;
  localparam logic [7:0] FC_PTE_NP   = 8'h06;
  localparam logic [7:0] FC_PTE_RSV  = 8'h07;
  localparam logic [7:0] FC_WR       = 8'h08;
  localparam logic [7:0] FC_RD       = 8'h09;

  typedef enum logic [1:0] {
    S_IDLE, S_ROOT, S_CTX, S_PTE
  } dtw_state_e;
endpackage

`default_nettype wire

// ==== design/dtw_walker.sv ====
// Remap table walker: root, context and page entries per DMA request.
// Assumes table memory answers each o_mem_req with one i_mem_valid;
// page entries come back in i_mem_data[63:0].
`default_nettype none

module dtw_walker
  import dtw_pkg::*;
#(
  parameter int         HPW     = 48,
  parameter int         DTW     = 16,
  parameter logic [7:0] GW_OK   = 8'h06,
  parameter logic [7:0] STOP_OK = 8'h0c
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic [7:0]   i_addr,
  input  wire logic [31:0]  i_wr_data,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output var  logic [31:0]  o_rd_data,
  input  wire logic         i_req_valid,
  input  wire logic [15:0]  i_req_tag,
  input  wire logic [63:0]  i_req_addr,
  input  wire logic         i_req_write,
  output var  logic         o_req_ready,
  output var  logic         o_mem_req,
  output var  logic [63:0]  o_mem_addr,
  input  wire logic         i_mem_valid,
  input  wire logic [127:0] i_mem_data,
  output var  logic         o_rsp_valid,
  output var  logic         o_rsp_ok,
  output var  logic [63:0]  o_rsp_addr,
  output var  logic [15:0]  o_rsp_domain,
  output var  logic         o_flt_valid,
  output var  logic [127:0] o_flt_record
);
  // Bits at or above the host width must read zero
  localparam logic [63:0] HI_MASK = ~((64'h1 << HPW) - 64'h1);
  localparam logic [15:0] DT_RSV  = 16'(~((32'h1 << DTW) - 32'h1));

  dtw_state_e   st;
  logic         en_reg;
  logic [63:0]  root_reg;
  logic [15:0]  tag_reg;
  logic [63:0]  va_reg;
  logic         wr_reg;
  logic         sil_reg;
  logic [2:0]   lvl_reg;
  logic [7:0]   cause_reg;
  logic [15:0]  fcnt_reg;
  logic [63:0]  root_ptr;
  logic [127:0] d;
  logic [63:0]  pe;
  logic         root_rsv;
  logic         ctx_rsv;
  logic         wexc;
  logic         pte_rsv;
  logic         fin;
  logic         sil;
  logic [7:0]   fc;
  logic [63:0]  hpa;
  logic [63:0]  nxt;
  logic [2:0]   gw;
  logic [6:0]   gbits;

  // ==========================================================
  // Entry decode
  assign d        = i_mem_data;
  assign pe       = i_mem_data[63:0];
  // Bus number indexes the root table, 16 bytes per entry
  assign root_ptr = root_reg + {52'h0, i_req_tag[15:8], 4'h0};
  assign gw       = d[GW_LSB +: 3];
  assign gbits    = GW_BASE + 7'(9 * gw);

  // Reserved bits of the root entry, checked only once present
  assign root_rsv = (|d[127:64]) | (|d[11:1])
                  | (|(d[63:0] & HI_MASK));

  // Spare bits 70:67 left out of every check
  assign ctx_rsv = (|d[127:88]) | d[71]
                 | (|(d[87:72] & DT_RSV))
                 | (|d[11:4]) | (|(d[63:0] & HI_MASK))
                 | (d[3:2] != 2'b00)
                 | (gw > GW_MAX) | !GW_OK[gw];

  // A 64-bit width leaves nothing above it to test
  assign wexc = (gbits < 7'd64)
              && ((va_reg >> gbits) != 64'h0);

  // Spare bits 11:8 are not looked at
  assign pte_rsv = (|pe[6:2]) | (|(pe & HI_MASK))
                 | (pe[STOP_BIT] && ((lvl_reg == 3'd1)
                   || !(STOP_DEF[lvl_reg]
                        && STOP_OK[lvl_reg])));

  // Bit position where a level's index starts
  function automatic logic [6:0] lvl_shift(input logic [2:0] l);
    lvl_shift = 7'(PAGE_LSB) + 7'(LVL_BITS * (l - 3'd1));
  endfunction

  // Address of the entry that a level selects in a table
  function automatic logic [63:0] pte_at(
    input logic [51:0] base,
    input logic [2:0]  l
  );
    logic [8:0] idx;
    idx    = 9'(va_reg >> lvl_shift(l));
    pte_at = {base, 12'h0} + {52'h0, idx, 3'h0};
  endfunction

  // ==========================================================
  // Walk decisions for the entry now returned
  always_comb begin
    logic [63:0] m;
    m   = (64'h1 << lvl_shift(lvl_reg)) - 64'h1;
    fin = 1'b0;
    fc  = FC_NONE;
    hpa = 64'h0;
    nxt = 64'h0;
    sil = 1'b0;
    case (st)
      S_ROOT: begin
        if (!d[PRESENT_BIT]) begin
          fin = 1'b1;
          fc  = FC_ROOT_NP;
        end else if (root_rsv) begin
          fin = 1'b1;
          fc  = FC_ROOT_RSV;
        end else begin
          // Device and function index the context table
          nxt = {d[63:12], 12'h0}
              + {52'h0, tag_reg[7:0], 4'h0};
        end
      end
      S_CTX: begin
        sil = d[SILENCE_BIT];
        if (!d[PRESENT_BIT]) begin
          fin = 1'b1;
          fc  = FC_CTX_NP;
        end else if (ctx_rsv) begin
          fin = 1'b1;
          fc  = FC_CTX_RSV;
        end else if (wexc) begin
          fin = 1'b1;
          fc  = FC_WIDTH;
        end else begin
          nxt = pte_at(d[63:12], gw + 3'd2);
        end
      end
      S_PTE: begin
        sil = sil_reg;
        if (!(pe[PTE_RD_BIT] | pe[PTE_WR_BIT])) begin
          fin = 1'b1;
          fc  = FC_PTE_NP;
        end else if (pte_rsv) begin
          fin = 1'b1;
          fc  = FC_PTE_RSV;
        end else if (wr_reg && !pe[PTE_WR_BIT]) begin
          fin = 1'b1;
          fc  = FC_WR;
        end else if (!wr_reg && !pe[PTE_RD_BIT]) begin
          fin = 1'b1;
          fc  = FC_RD;
        end else if (lvl_reg == 3'd1 || pe[STOP_BIT]) begin
          fin = 1'b1;
          hpa = ({pe[63:12], 12'h0} & ~HI_MASK & ~m)
              | (va_reg & m);
        end else begin
          nxt = pte_at(pe[63:12], lvl_reg - 3'd1);
        end
      end
      default: begin
        fin = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      en_reg   <= CTRL_RST;
      root_reg <= ROOT_RST;
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL:    en_reg          <= i_wr_data[0];
        REG_ROOT_LO: root_reg[31:12] <= i_wr_data[31:12];
        REG_ROOT_HI: root_reg[63:32] <= i_wr_data;
        default:     en_reg          <= en_reg;
      endcase
    end
  end

  // Read data stands one cycle after the strobe, else zero
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rd_data <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL:    o_rd_data <= {31'h0, en_reg};
        REG_ROOT_LO: o_rd_data <= root_reg[31:0];
        REG_ROOT_HI: o_rd_data <= root_reg[63:32];
        REG_STATUS:  o_rd_data <= {fcnt_reg, cause_reg, 7'h0,
                                   st != S_IDLE};
        default:     o_rd_data <= 32'h0;
      endcase
    end else begin
      o_rd_data <= 32'h0;
    end
  end

  // Last cause and a saturating count of blocked requests
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cause_reg <= FC_NONE;
      fcnt_reg  <= 16'h0;
    end else if (st != S_IDLE && i_mem_valid && fin
                 && fc != FC_NONE) begin
      cause_reg <= fc;
      if (fcnt_reg != 16'hffff) begin
        fcnt_reg <= fcnt_reg + 16'h1;
      end
    end
  end

  // ==========================================================
  // Walk sequencer; one request in flight, no caching
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st           <= S_IDLE;
      o_req_ready  <= 1'b0;
      o_mem_req    <= 1'b0;
      o_mem_addr   <= 64'h0;
      o_rsp_valid  <= 1'b0;
      o_rsp_ok     <= 1'b0;
      o_rsp_addr   <= 64'h0;
      o_rsp_domain <= 16'h0;
      o_flt_valid  <= 1'b0;
      o_flt_record <= 128'h0;
      tag_reg      <= 16'h0;
      va_reg       <= 64'h0;
      wr_reg       <= 1'b0;
      sil_reg      <= 1'b0;
      lvl_reg      <= 3'd0;
    end else begin
      o_mem_req   <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_flt_valid <= 1'b0;
      case (st)
        S_IDLE: begin
          if (i_req_valid && o_req_ready) begin
            tag_reg     <= i_req_tag;
            va_reg      <= i_req_addr;
            wr_reg      <= i_req_write;
            sil_reg     <= 1'b0;
            o_req_ready <= 1'b0;
            o_mem_req   <= 1'b1;
            o_mem_addr  <= root_ptr;
            st          <= S_ROOT;
          end else begin
            o_req_ready <= en_reg; // Disabled walker stalls requesters
          end
        end
        S_ROOT, S_CTX, S_PTE: begin
          if (i_mem_valid && fin) begin
            o_rsp_valid <= 1'b1;
            o_rsp_ok    <= fc == FC_NONE;
            o_rsp_addr  <= hpa;
            o_flt_valid <= fc != FC_NONE && !sil;
            o_flt_record <= '0;
            o_flt_record[REC_TYPE] <= !wr_reg;
            o_flt_record[REC_CAUSE +: 8] <= fc;
            o_flt_record[REC_REQ +: 16] <= tag_reg;
            o_flt_record[63:12] <= va_reg[63:12];
            o_req_ready <= en_reg;
            st          <= S_IDLE;
          end else if (i_mem_valid) begin
            o_mem_req  <= 1'b1;
            o_mem_addr <= nxt;
            if (st == S_CTX) begin
              sil_reg      <= sil;
              lvl_reg      <= gw + 3'd2;
              o_rsp_domain <= d[TAG_LSB +: 16] & ~DT_RSV;
            end else if (st == S_PTE) begin
              lvl_reg <= lvl_reg - 3'd1;
            end
            st <= (st == S_ROOT) ? S_CTX : S_PTE;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks on the walk
  a_root_block: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_ROOT && i_mem_valid && !d[0]
    |=> o_rsp_valid && !o_rsp_ok && !o_mem_req)
    else $error("root not present did not block");

  a_ctx_block: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_CTX && i_mem_valid && !d[0]
    |=> o_rsp_valid && !o_rsp_ok)
    else $error("context not present did not block");

  a_silence_ctx: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_CTX && i_mem_valid && d[1] && !d[0]
    |=> !o_flt_valid)
    else $error("silenced fault was reported");

  a_ctx_pointer: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_ROOT && i_mem_valid && d[0] && !root_rsv
    |=> o_mem_req && o_mem_addr[63:12] == $past(d[63:12]))
    else $error("context table base wrong");

  a_root_index: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_IDLE && i_req_valid && o_req_ready
    |=> o_mem_req && o_mem_addr == $past(root_ptr) ##1 !o_mem_req)
    else $error("root entry address wrong");

  a_write_perm: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_PTE && i_mem_valid && wr_reg && pe[0] && !pe[1]
    |=> o_rsp_valid && !o_rsp_ok)
    else $error("write through read-only page passed");

  a_record_type: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    o_flt_valid |-> o_flt_record[126] == !wr_reg
                    && o_rsp_valid && !o_rsp_ok)
    else $error("fault record type wrong");

  a_record_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    o_flt_valid |-> o_flt_record[127] == 1'b0
      && o_flt_record[125:104] == 22'h0
      && o_flt_record[95:80] == 16'h0
      && o_flt_record[79:64] == tag_reg
      && o_flt_record[11:0] == 12'h0)
    else $error("fault record layout wrong");

  c_translate_ok: cover property (
    @(posedge i_mclk) disable iff (i_rst)
    o_rsp_valid && o_rsp_ok);
  c_root_absent: cover property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_ROOT && i_mem_valid && !d[0]);
  c_large_stop: cover property (
    @(posedge i_mclk) disable iff (i_rst)
    st == S_PTE && i_mem_valid && fin && fc == FC_NONE
    && lvl_reg > 3'd1);

endmodule

`default_nettype wire

// ==== test/dtw_mem_model.sv ====
// Table memory model standing in for host memory behind the walker.
// Assumes one table read in flight at a time and a latency of 1 or more.
`default_nettype none

module dtw_mem_model (
  input  wire logic         i_mclk,
  input  wire logic         i_mem_req,
  input  wire logic [63:0]  i_mem_addr,
  input  wire logic [3:0]   i_lat,
  output var  logic         o_mem_valid,
  output var  logic [127:0] o_mem_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [127:0] mem [logic [63:0]];
  logic [127:0] last;

  // ==========================================================
  // Bench access: entries are placed straight into the table
  task automatic put(input logic [63:0] a, input logic [127:0] d);
    mem[a] = d;
  endtask

  // ==========================================================
  // Answer each read after i_lat cycles; absent entries read as zero.
  // Between answers the lines carry the inverse of the last entry, so
  // a walker that samples data outside the valid pulse is caught.
  initial begin
    o_mem_valid = 1'b0;
    o_mem_data  = '1;
    forever begin
      @(posedge i_mclk);
      if (i_mem_req) begin
        last = mem.exists(i_mem_addr) ? mem[i_mem_addr] : '0;
        repeat (i_lat - 4'd1) @(posedge i_mclk);
        o_mem_valid <= 1'b1;
        o_mem_data  <= last;
        @(posedge i_mclk);
        o_mem_valid <= 1'b0;
        o_mem_data  <= ~last;
      end
    end
  end
endmodule

`default_nettype wire

// ==== test/test_dma_remap_table_walker.sv ====
// Bench of the remap table walker: builds tables in the memory model,
// sends DMA requests and judges responses and fault records.
// Assumes dtw_pkg, the walker and the memory model are compiled first.
`default_nettype none

module test_dma_remap_table_walker
  import dtw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [63:0] VA    = 64'h4040_3abc;
  localparam logic [63:0] PA    = 64'ha_bcde_fabc;
  localparam logic [15:0] TAG   = 16'h0208;
  localparam logic [63:0] ROOTA = 64'h1_0020;
  localparam logic [63:0] CTXA  = 64'h2_0080;
  localparam logic [63:0] L2    = 64'h4_0010;
  localparam logic [63:0] LEAF  = 64'h5_0018;
  localparam logic [63:0] HI    = 64'h3479;

  logic         i_mclk      = 1'b0;
  logic         i_rst       = 1'b1;
  logic [7:0]   i_addr      = 8'h00;
  logic [31:0]  i_wr_data   = 32'h0;
  logic         i_wr        = 1'b0;
  logic         i_rd        = 1'b0;
  logic         i_req_valid = 1'b0;
  logic [63:0]  i_req_addr  = 64'h0;
  logic         i_req_write = 1'b0;
  logic [3:0]   lat         = 4'h1;
  logic [15:0]  i_req_tag   = TAG;
  logic         i_mem_valid;
  logic [127:0] i_mem_data;
  logic [31:0]  o_rd_data;
  logic         o_req_ready, o_mem_req, o_rsp_valid, o_rsp_ok, o_flt_valid;
  logic [63:0]  o_mem_addr, o_rsp_addr;
  logic [15:0]  o_rsp_domain;
  logic [127:0] o_flt_record;
  int           n_mismatch  = 0;
  int           checks      = 0;

  // Narrow tag width so the upper tag bits become reserved
  dtw_walker #(.DTW(8)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .i_req_valid(i_req_valid),
    .i_req_tag(i_req_tag), .i_req_addr(i_req_addr),
    .i_req_write(i_req_write), .o_req_ready(o_req_ready),
    .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .i_mem_valid(i_mem_valid), .i_mem_data(i_mem_data),
    .o_rsp_valid(o_rsp_valid), .o_rsp_ok(o_rsp_ok),
    .o_rsp_addr(o_rsp_addr), .o_rsp_domain(o_rsp_domain),
    .o_flt_valid(o_flt_valid), .o_flt_record(o_flt_record));

  dtw_mem_model mem (
    .i_mclk(i_mclk), .i_mem_req(o_mem_req), .i_mem_addr(o_mem_addr),
    .i_lat(lat), .o_mem_valid(i_mem_valid), .o_mem_data(i_mem_data));

  // ==========================================================
  // Clock, checks and closing
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic chk(input string s, input logic [127:0] g, e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus tasks: entered right after a rising edge, leave on one
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr      <= 1'b1;
    @(posedge i_mclk);
    i_wr      <= 1'b0;
  endtask

  // Read data is looked at in the one cycle it stands
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    @(posedge i_mclk);
    chk("rd_data", o_rd_data, e);
  endtask

  // One DMA request, judged on the response and the fault record
  task automatic xfer(input logic [63:0] va, input logic w,
                      input logic [7:0] fc, input logic [63:0] pa,
                      input logic flt);
    int n;
    n = 0;
    i_req_valid <= 1'b1;
    i_req_addr  <= va;
    i_req_write <= w;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_req_ready !== 1'b1 && n < 100);
    i_req_valid <= 1'b0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_rsp_valid !== 1'b1 && n < 200);
    chk("rsp_valid", o_rsp_valid, 1'b1);
    chk("rsp_ok", o_rsp_ok, fc == FC_NONE);
    chk("rsp_addr", o_rsp_addr, pa);
    chk("flt_valid", o_flt_valid, flt);
    if (flt) begin
      chk("flt_record", o_flt_record,
          {1'b0, !w, 22'h0, fc, 16'h0, i_req_tag, va[63:12], 12'h0});
    end
    if (fc == FC_NONE) begin
      chk("rsp_domain", o_rsp_domain, 16'h0034);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    chk("req_ready", o_req_ready, 1'b0);
    reg_rd(REG_CTRL, 32'h0);
    reg_wr(REG_CTRL, 32'h1);
    reg_wr(REG_ROOT_LO, 32'h0001_0fff);
    reg_wr(REG_ROOT_HI, 32'h0);
    reg_rd(REG_ROOT_LO, 32'h0001_0000);
    reg_rd(8'h40, 32'h0);
    chk("req_ready", o_req_ready, 1'b1);
  endtask

  // Spare bits set in context and leaf must not disturb the walk
  task automatic t_walk;
    mem.put(ROOTA, {64'h0, 64'h2_0001});
    mem.put(CTXA, {HI, 64'h3_0001});
    mem.put(64'h3_0008, 128'h4_0003);
    mem.put(L2, 128'h5_0003);
    mem.put(LEAF, 128'ha_bcde_ff01);
    xfer(VA, 1'b0, FC_NONE, PA, 1'b0);
    xfer(VA, 1'b1, FC_WR, 64'h0, 1'b1);
    lat <= 4'h4;
    mem.put(LEAF, 128'ha_bcde_ff02);
    xfer(VA, 1'b0, FC_RD, 64'h0, 1'b1);
    lat <= 4'h1;
    xfer(VA, 1'b1, FC_NONE, PA, 1'b0);
    mem.put(LEAF, 128'ha_bcde_ff04);
    xfer(VA, 1'b0, FC_PTE_NP, 64'h0, 1'b1);
    mem.put(LEAF, 128'ha_bcde_ff05);
    xfer(VA, 1'b0, FC_PTE_RSV, 64'h0, 1'b1);
  endtask

  task automatic t_stop;
    mem.put(L2, 128'h60_0083);
    xfer(VA, 1'b0, FC_NONE, 64'h60_3abc, 1'b0);
    mem.put(64'h3_0008, 128'h4000_0083);
    xfer(VA, 1'b1, FC_NONE, 64'h4040_3abc, 1'b0);
    mem.put(64'h3_0008, 128'h4_0003);
    mem.put(L2, 128'h5_0003);
    mem.put(LEAF, 128'ha_bcde_ff83);
    xfer(VA, 1'b0, FC_PTE_RSV, 64'h0, 1'b1);
    mem.put(LEAF, 128'ha_bcde_ff03);
  endtask

  // Context faults; silenced faults still block the request
  task automatic t_ctx;
    xfer(64'h80_0000_0000, 1'b0, FC_WIDTH, 64'h0, 1'b1);
    mem.put(CTXA, {HI | 64'h4, 64'h3_0001});
    xfer(VA, 1'b0, FC_CTX_RSV, 64'h0, 1'b1);
    mem.put(CTXA, {HI & ~64'h1, 64'h3_0001});
    xfer(VA, 1'b0, FC_CTX_RSV, 64'h0, 1'b1);
    mem.put(CTXA, {HI, 64'h3_0005});
    xfer(VA, 1'b0, FC_CTX_RSV, 64'h0, 1'b1);
    mem.put(CTXA, {HI | 64'h80, 64'h3_0001});
    xfer(VA, 1'b0, FC_CTX_RSV, 64'h0, 1'b1);
    mem.put(CTXA, {HI | 64'h12_0000, 64'h3_0001});
    xfer(VA, 1'b0, FC_CTX_RSV, 64'h0, 1'b1);
    mem.put(CTXA, {HI | 64'h80, 64'h3_0010});
    xfer(VA, 1'b0, FC_CTX_NP, 64'h0, 1'b1);
    mem.put(CTXA, {HI, 64'h3_0012});
    xfer(VA, 1'b0, FC_CTX_NP, 64'h0, 1'b0);
    mem.put(LEAF, 128'ha_bcde_ff01);
    mem.put(CTXA, {HI, 64'h3_0003});
    xfer(VA, 1'b1, FC_WR, 64'h0, 1'b0);
    mem.put(CTXA, {HI, 64'h3_0001});
  endtask

  task automatic t_root;
    mem.put(ROOTA, {64'h1, 64'h2_0000});
    xfer(VA, 1'b0, FC_ROOT_NP, 64'h0, 1'b1);
    mem.put(ROOTA, {64'h1, 64'h2_0001});
    xfer(VA, 1'b0, FC_ROOT_RSV, 64'h0, 1'b1);
    mem.put(ROOTA, {64'h0, 64'h1_0000_0002_0001});
    xfer(VA, 1'b0, FC_ROOT_RSV, 64'h0, 1'b1);
    mem.put(ROOTA, {64'h0, 64'h2_0001});
    // Other bus finds no root entry, other dev/fn no context entry
    i_req_tag <= 16'h0508;
    xfer(VA, 1'b0, FC_ROOT_NP, 64'h0, 1'b1);
    i_req_tag <= 16'h0209;
    xfer(VA, 1'b0, FC_CTX_NP, 64'h0, 1'b1);
    i_req_tag <= TAG;
    xfer(VA, 1'b0, FC_NONE, PA, 1'b0);
    // Nineteen blocked requests so far, the last one a context miss
    reg_rd(REG_STATUS, 32'h0013_0300);
  endtask

  // ==========================================================
  // Main sequence and watchdog; a whole run takes a few hundred cycles
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_regs();
    t_walk();
    t_stop();
    t_ctx();
    t_root();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    conclude();
  end
endmodule

`default_nettype wire
